// *** design/epw_consts.svh ***
// constants for the eeprom page-write and write-protect block
// assumes a 50 MHz system clock and an spi link sampled by it
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH

// opcodes, with bit 3 masked off before comparing
`define EPW_OPC_MASK 8'hf7
`define EPW_OPC_LATCH_SET 8'h06
`define EPW_OPC_LATCH_CLR 8'h04
`define EPW_OPC_STATUS_READ 8'h05
`define EPW_OPC_STATUS_WRITE 8'h01
`define EPW_OPC_WRITE 8'h02

// address layout
`define EPW_ADDR_W 14
`define EPW_PAGE_W 8
`define EPW_OFS_W 6
`define EPW_PAGE_BYTES 64
`define EPW_ADDR_LAST_BIT 4'hf

// status byte field positions
`define EPW_SR_ARM_BIT 7
`define EPW_SR_BG1_BIT 3
`define EPW_SR_BG0_BIT 2

// reset values of the status bits
`define EPW_RST_ARM 1'b0
`define EPW_RST_BG 2'h0
`define EPW_RST_LATCH 1'b0

// write cycle time
`define EPW_TWC_US 5000
`define EPW_CLK_MHZ 50
`define EPW_TWC_CYCLES (`EPW_TWC_US * `EPW_CLK_MHZ)

// commit fifo shape
`define EPW_FIFO_DEPTH 16
`define EPW_FIFO_WIDTH 22

`endif

// *** design/epw_pkg.sv ***
// types shared by the eeprom page-write block
// assumes epw_consts.svh for the numeric constants
package epw_pkg;

  // link decoder phases
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_OPC,
    LK_ADDR,
    LK_DATA,
    LK_SKIP
  } epw_link_e;

  // command captured for the end of the transaction
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_LATCH_SET,
    CMD_LATCH_CLR,
    CMD_STATUS_WRITE,
    CMD_WRITE
  } epw_cmd_e;

  // internal write cycle phases
  typedef enum logic [1:0] {
    WC_IDLE,
    WC_SCAN,
    WC_WAIT
  } epw_wc_e;

endpackage

// *** design/epw_sync.sv ***
// three-stage synchroniser with agreement filter for one pin
// assumes an asynchronous pin; output changes when stages two and three agree
`timescale 1ns/1ps
module epw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic lvl_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // shift chain, then accept only an agreed level
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_out <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        lvl_out <= s3_q;
    end
  end

endmodule

// *** design/epw_fifo.sv ***
// synchronous fifo with valid/ready on both sides
// assumes one clock; width and depth are parameters, depth a power of two
`timescale 1ns/1ps
module epw_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  logic full;
  logic empty;

  // full when pointers differ only in the wrap bit
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out = mem[rd_q[AW-1:0]];
  assign push = in_valid_in & ~full;
  assign pop = out_ready_in & ~empty;

  // pointers
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data_in;
  end

endmodule

// *** design/epw_top.sv ***
// page-write and write-protect logic of a serial eeprom behind an spi link
// assumes spi pins asynchronous to ref_clk_in; array writes leave by a
// valid/ready port; status-read answer and hold are handled elsewhere
`timescale 1ns/1ps
`include "epw_consts.svh"

module epw_top #(
  parameter int TWC_CYCLES = `EPW_TWC_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_b_in,
  input wire logic spi_mosi_in,
  input wire logic protect_b_in,
  input wire logic mem_wr_ready_in,
  output logic mem_wr_valid_out,
  output logic [`EPW_ADDR_W-1:0] mem_wr_addr_out,
  output logic [7:0] mem_wr_data_out,
  output logic write_latch_out,
  output logic hw_protect_arm_out,
  output logic block_guard_bit0_out,
  output logic block_guard_bit1_out,
  output logic hw_protect_on_out,
  output logic busy_out
);

  import epw_pkg::*;

  logic sck_lvl;
  logic cs_b_lvl;
  logic mosi_lvl;
  logic prot_b_lvl;
  logic sck_prev_q;
  logic cs_prev_q;

  epw_link_e lk_q;
  epw_link_e lk_d;
  epw_cmd_e cmd_q;
  epw_wc_e wc_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [15:0] addr_q;
  logic [`EPW_PAGE_W-1:0] page_q;
  logic [`EPW_OFS_W-1:0] ptr_q;
  logic got_data_q;
  logic [7:0] sr_new_q;
  logic [`EPW_PAGE_BYTES-1:0] valid_q;
  logic [7:0] pbuf [0:`EPW_PAGE_BYTES-1];
  logic [`EPW_OFS_W-1:0] scan_q;
  logic [17:0] timer_q;
  logic sr_pend_q;
  logic latch_q;
  logic arm_q;
  logic [1:0] bg_q;

  // pin synchronisers; chip select idles high
  epw_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(spi_sck_in), .lvl_out(sck_lvl));
  epw_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(spi_cs_b_in), .lvl_out(cs_b_lvl));
  epw_sync #(.RST_VAL(1'b0)) u_sync_mosi (
    .clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(spi_mosi_in), .lvl_out(mosi_lvl));
  epw_sync #(.RST_VAL(1'b1)) u_sync_prot (
    .clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(protect_b_in), .lvl_out(prot_b_lvl));

  // edge detection on the filtered link levels
  logic sck_rise;
  logic cs_fall;
  logic cs_rise;
  logic bit_take;
  logic byte_done;
  logic addr_done;
  logic [7:0] shift_d;
  logic [15:0] addr_d;
  logic [7:0] opc;
  logic busy;
  assign sck_rise = sck_lvl & ~sck_prev_q;
  assign cs_fall = ~cs_b_lvl & cs_prev_q;
  assign cs_rise = cs_b_lvl & ~cs_prev_q;
  assign bit_take = sck_rise & ~cs_b_lvl;
  assign shift_d = {shift_q[6:0], mosi_lvl}; // msb first
  assign addr_d = {addr_q[14:0], mosi_lvl};
  assign byte_done = bit_take & (cnt_q[2:0] == 3'h7);
  assign addr_done = bit_take & (lk_q == LK_ADDR) &
    (cnt_q == `EPW_ADDR_LAST_BIT);
  assign opc = shift_d & `EPW_OPC_MASK;
  assign busy = (wc_q != WC_IDLE);

  // opcode decode
  logic is_set;
  logic is_clr;
  logic is_srw;
  logic is_wr;
  assign is_set = (opc == `EPW_OPC_LATCH_SET);
  assign is_clr = (opc == `EPW_OPC_LATCH_CLR);
  assign is_srw = (opc == `EPW_OPC_STATUS_WRITE);
  assign is_wr = (opc == `EPW_OPC_WRITE);

  // protection terms
  logic hw_on;
  logic opc_end;
  assign hw_on = arm_q & ~prot_b_lvl;
  assign opc_end = byte_done & (lk_q == LK_OPC) & ~busy;

  // link phase sequencing
  always_comb
  begin
    lk_d = lk_q;
    case (lk_q)
      LK_IDLE:
        if (cs_fall)
          lk_d = LK_OPC;
      LK_OPC:
        if (byte_done)
        begin
          if (busy)
            lk_d = LK_SKIP;
          else if (is_wr)
            lk_d = LK_ADDR;
          else if (is_srw)
            lk_d = LK_DATA;
          else
            lk_d = LK_SKIP;
        end
      LK_ADDR:
        if (addr_done)
          lk_d = LK_DATA;
      LK_DATA:
        lk_d = LK_DATA;
      LK_SKIP:
        lk_d = LK_SKIP;
      default:
        lk_d = LK_IDLE;
    endcase
    if (cs_b_lvl)
      lk_d = LK_IDLE;
  end

  // link registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      lk_q <= LK_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addr_q <= 16'h0000;
    end
    else
    begin
      sck_prev_q <= sck_lvl;
      cs_prev_q <= cs_b_lvl;
      lk_q <= lk_d;
      if (cs_fall)
        cnt_q <= 4'h0;
      else if (bit_take)
        cnt_q <= (byte_done && lk_q == LK_OPC) ? 4'h0 : cnt_q + 4'h1;
      if (bit_take)
        shift_q <= shift_d;
      if (bit_take && lk_q == LK_ADDR)
        addr_q <= addr_d;
    end
  end

  // command capture and data landing
  logic land;
  assign land = byte_done & (lk_q == LK_DATA);
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cmd_q <= CMD_NONE;
      page_q <= '0;
      ptr_q <= '0;
      got_data_q <= 1'b0;
      sr_new_q <= 8'h00;
    end
    else
    begin
      if (cs_fall)
      begin
        cmd_q <= CMD_NONE;
        got_data_q <= 1'b0;
      end
      else if (opc_end)
      begin
        if (is_set)
          cmd_q <= CMD_LATCH_SET;
        else if (is_clr)
          cmd_q <= CMD_LATCH_CLR;
        else if (is_srw)
          cmd_q <= CMD_STATUS_WRITE;
        else if (is_wr)
          cmd_q <= CMD_WRITE;
        else
          cmd_q <= CMD_NONE;
      end
      if (addr_done)
      begin
        page_q <= addr_d[`EPW_ADDR_W-1:`EPW_OFS_W];
        ptr_q <= addr_d[`EPW_OFS_W-1:0];
      end
      else if (land && cmd_q == CMD_WRITE)
        ptr_q <= ptr_q + 6'h01; // wraps inside the page
      if (land)
        got_data_q <= 1'b1;
      if (land && cmd_q == CMD_STATUS_WRITE && !got_data_q)
        sr_new_q <= shift_d;
    end
  end

  // page buffer valid mask, cleared at each write opcode taken while not busy
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      valid_q <= '0;
    else if (opc_end && is_wr)
      valid_q <= '0;
    else if (land && cmd_q == CMD_WRITE)
      valid_q[ptr_q] <= 1'b1;
  end

  // page buffer data; later bytes overwrite earlier ones
  always_ff @(posedge ref_clk_in)
  begin
    if (land && cmd_q == CMD_WRITE)
      pbuf[ptr_q] <= shift_d;
  end

  // end-of-transaction decisions
  logic start_wr;
  logic start_sr;
  logic fifo_in_ready;
  logic scan_prot;
  logic push;
  logic advance;
  logic scan_last;
  logic wait_done;
  logic [`EPW_ADDR_W-1:0] scan_addr;
  assign start_wr = cs_rise & (cmd_q == CMD_WRITE) & got_data_q &
    latch_q;
  assign start_sr = cs_rise & (cmd_q == CMD_STATUS_WRITE) & got_data_q &
    latch_q & ~hw_on;
  assign scan_addr = {page_q, scan_q};
  assign scan_prot = (bg_q == 2'h3) |
    ((bg_q == 2'h2) & scan_addr[13]) |
    ((bg_q == 2'h1) & (scan_addr[13:12] == 2'h3));
  assign push = (wc_q == WC_SCAN) & valid_q[scan_q] & ~scan_prot;
  assign advance = (wc_q == WC_SCAN) & (~push | fifo_in_ready);
  assign scan_last = (scan_q == 6'h3f);
  assign wait_done = (wc_q == WC_WAIT) &
    (timer_q == 18'(TWC_CYCLES - 1));

  // internal write cycle: scan the page on a page write, then hold busy for the cycle time
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wc_q <= WC_IDLE;
      scan_q <= '0;
      timer_q <= 18'h00000;
      sr_pend_q <= 1'b0;
    end
    else
    begin
      case (wc_q)
        WC_IDLE:
        begin
          scan_q <= '0;
          timer_q <= 18'h00000;
          if (start_wr)
            wc_q <= WC_SCAN;
          else if (start_sr)
          begin
            wc_q <= WC_WAIT;
            sr_pend_q <= 1'b1;
          end
        end
        WC_SCAN:
          if (advance)
          begin
            scan_q <= scan_q + 6'h01;
            if (scan_last)
              wc_q <= WC_WAIT;
          end
        WC_WAIT:
        begin
          timer_q <= timer_q + 18'h00001;
          if (wait_done)
          begin
            wc_q <= WC_IDLE;
            sr_pend_q <= 1'b0;
          end
        end
        default:
          wc_q <= WC_IDLE;
      endcase
    end
  end

  // write latch and nonvolatile status bits
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      latch_q <= `EPW_RST_LATCH;
      arm_q <= `EPW_RST_ARM;
      bg_q <= `EPW_RST_BG;
    end
    else
    begin
      if (wait_done)
        latch_q <= 1'b0;
      else if (cs_rise && cmd_q == CMD_LATCH_SET)
        latch_q <= 1'b1;
      else if (cs_rise && cmd_q == CMD_LATCH_CLR)
        latch_q <= 1'b0;
      if (wait_done && sr_pend_q)
      begin
        arm_q <= sr_new_q[`EPW_SR_ARM_BIT];
        bg_q <= {sr_new_q[`EPW_SR_BG1_BIT], sr_new_q[`EPW_SR_BG0_BIT]};
      end
    end
  end

  // commit fifo between page scan and the array port
  logic [`EPW_FIFO_WIDTH-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  assign fifo_out_ready = ~mem_wr_valid_out | mem_wr_ready_in;
  epw_fifo #(.WIDTH(`EPW_FIFO_WIDTH), .DEPTH(`EPW_FIFO_DEPTH)) u_fifo (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({scan_addr, pbuf[scan_q]}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // registered array port and status outputs
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mem_wr_valid_out <= 1'b0;
      mem_wr_addr_out <= '0;
      mem_wr_data_out <= 8'h00;
      write_latch_out <= `EPW_RST_LATCH;
      hw_protect_arm_out <= `EPW_RST_ARM;
      block_guard_bit0_out <= 1'b0;
      block_guard_bit1_out <= 1'b0;
      hw_protect_on_out <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      if (fifo_out_ready)
      begin
        mem_wr_valid_out <= fifo_out_valid;
        mem_wr_addr_out <= fifo_out_data[21:8];
        mem_wr_data_out <= fifo_out_data[7:0];
      end
      write_latch_out <= latch_q;
      hw_protect_arm_out <= arm_q;
      block_guard_bit0_out <= bg_q[0];
      block_guard_bit1_out <= bg_q[1];
      hw_protect_on_out <= hw_on;
      busy_out <= busy;
    end
  end

endmodule

// *** tb/epw_top_assertions.sv ***
// port checker for epw_top
// assumes binding to epw_top, one clock domain
`timescale 1ns/1ps
`include "epw_consts.svh"
module epw_top_chk (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic mem_wr_ready_in,
  input wire logic mem_wr_valid_out,
  input wire logic [`EPW_ADDR_W-1:0] mem_wr_addr_out,
  input wire logic [7:0] mem_wr_data_out,
  input wire logic write_latch_out,
  input wire logic hw_protect_arm_out,
  input wire logic block_guard_bit0_out,
  input wire logic block_guard_bit1_out,
  input wire logic hw_protect_on_out,
  input wire logic busy_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // stalled beat, then two beats in a row
  sequence s_stall;
    mem_wr_valid_out && !mem_wr_ready_in;
  endsequence
  sequence s_two_beats;
    mem_wr_valid_out && mem_wr_ready_in ##1 mem_wr_valid_out;
  endsequence
  property p_hold;
    s_stall |=> mem_wr_valid_out && $stable(mem_wr_addr_out)
      && $stable(mem_wr_data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("array beat changed while stalled");
  property p_guard;
    mem_wr_valid_out |-> !(block_guard_bit1_out && block_guard_bit0_out)
      && !(block_guard_bit1_out && mem_wr_addr_out[13])
      && !(block_guard_bit0_out && (&mem_wr_addr_out[13:12]));
  endproperty
  a_guard: assert property (p_guard)
    else $error("guarded byte written");
  property p_latch;
    mem_wr_valid_out |-> write_latch_out && busy_out;
  endproperty
  a_latch: assert property (p_latch)
    else $error("array beat without latch or busy");
  property p_page;
    s_two_beats |-> mem_wr_addr_out[13:6] == $past(mem_wr_addr_out[13:6])
      && mem_wr_addr_out[5:0] > $past(mem_wr_addr_out[5:0]);
  endproperty
  a_page: assert property (p_page)
    else $error("beats leave page or repeat offset");
  property p_end;
    $fell(busy_out) |-> !write_latch_out;
  endproperty
  a_end: assert property (p_end)
    else $error("latch still set after write cycle");
  property p_ign;
    $rose(write_latch_out) |-> !busy_out;
  endproperty
  a_ign: assert property (p_ign)
    else $error("latch set during write cycle");
  property p_arm_on;
    hw_protect_on_out |-> hw_protect_arm_out || $past(hw_protect_arm_out);
  endproperty
  a_arm_on: assert property (p_arm_on)
    else $error("protection on without arm");
  property p_status;
    $changed({hw_protect_arm_out, block_guard_bit1_out, block_guard_bit0_out})
      |-> !busy_out && ($past(busy_out) || $past(busy_out, 2));
  endproperty
  a_status: assert property (p_status)
    else $error("status bits changed outside cycle end");
endmodule

bind epw_top epw_top_chk u_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .mem_wr_ready_in(mem_wr_ready_in), .mem_wr_valid_out(mem_wr_valid_out),
  .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
  .write_latch_out(write_latch_out), .hw_protect_arm_out(hw_protect_arm_out),
  .block_guard_bit0_out(block_guard_bit0_out),
  .block_guard_bit1_out(block_guard_bit1_out),
  .hw_protect_on_out(hw_protect_on_out), .busy_out(busy_out)
);

// *** tb/epw_spi_host.sv ***
// spi host model, mode 0 or mode 3, 160 ns bit period
// assumes the bench calls send with whole bytes only
`timescale 1ns/1ps
module epw_spi_host (
  output logic sck_out,
  output logic cs_b_out,
  output logic mosi_out
);
  bit cpol = 1'b0;
  // idle: deselected, clock parked low
  initial
  begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one frame, msb first, cs raised before any further rising clock edge
  task automatic send(input logic [7:0] q[$]);
    cs_b_out = 1'b0;
    foreach (q[i])
      for (int b = 7; b >= 0; b--)
      begin
        sck_out = 1'b0;
        mosi_out = q[i][b];
        #80 sck_out = 1'b1;
        #80;
      end
    sck_out = cpol; // park at the idle level of the mode
    #40 cs_b_out = 1'b1;
    mosi_out = ~mosi_out; // released line shows no stale bit
    #400;
  endtask
  // change clock idle level between frames only, cs stays high
  task automatic park(input bit p);
    cpol = p;
    sck_out = p;
    #400;
  endtask
endmodule

// *** tb/test_eeprom_page_write_protect.sv ***
// self-checking bench for epw_top
// assumes epw_spi_host as link partner and the bound port checker
`timescale 1ns/1ps
module test_eeprom_page_write_protect;
  import epw_pkg::*;
  logic ref_clk_in, rst_b_in = 1'b0, protect_b_in = 1'b1, rdy = 1'b1;
  logic sck, cs_b, mosi, vld, latch, arm, g0, g1, hw_on, busy;
  logic [13:0] wa;
  logic [7:0] wd;
  logic [21:0] expq[$], gotq[$];
  int fails = 0, checks = 0, seed = 85274, cyc = 0;
  bit latch_m = 0, arm_m = 0, stall = 0;
  bit [1:0] bg_m = 2'h0;

  epw_spi_host host (.sck_out(sck), .cs_b_out(cs_b), .mosi_out(mosi));
  epw_top #(.TWC_CYCLES(200)) dut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .spi_sck_in(sck),
    .spi_cs_b_in(cs_b), .spi_mosi_in(mosi), .protect_b_in(protect_b_in),
    .mem_wr_ready_in(rdy), .mem_wr_valid_out(vld), .mem_wr_addr_out(wa),
    .mem_wr_data_out(wd), .write_latch_out(latch), .hw_protect_arm_out(arm),
    .block_guard_bit0_out(g0), .block_guard_bit1_out(g1),
    .hw_protect_on_out(hw_on), .busy_out(busy));

  // clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // array side: random ready, beat capture, hang limit
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (vld === 1'b1 && rdy === 1'b1)
      gotq.push_back({wa, wd});
    rdy <= #1 !stall && $random(seed) % 3 != 0;
    if (cyc > 60000)
    begin
      fails++;
      conclude();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function bit guarded(input logic [13:0] a);
    return bg_m == 2'h3 || (bg_m == 2'h2 && a[13])
      || (bg_m == 2'h1 && a[13:12] == 2'h3);
  endfunction
  // send a frame and wait out any write cycle
  task cmd(input logic [7:0] q[$]);
    int n;
    host.send(q);
    n = 0;
    while (busy !== 1'b0 && n < 9000)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (3) @(posedge ref_clk_in);
  endtask
  task lset(input logic [7:0] op);
    cmd('{op});
    latch_m = 1;
    check(latch, 1);
  endtask
  task sw(input logic [7:0] b);
    cmd('{8'h01, b});
    if (latch_m && !(arm_m && !protect_b_in))
    begin
      {arm_m, bg_m} = {b[7], b[3:2]};
      latch_m = 0;
    end
    check({latch, arm, g1, g0}, {latch_m, arm_m, bg_m});
  endtask
  // page write of n random bytes, expected beats in offset order
  task wr(input logic [15:0] a, input int n);
    logic [7:0] q[$];
    logic [7:0] pg[64];
    bit v[64];
    int o;
    q = '{8'h02, a[15:8], a[7:0]};
    v = '{default: 0};
    o = a[5:0];
    for (int i = 0; i < n; i++)
    begin
      pg[o] = $random(seed);
      v[o] = 1;
      q.push_back(pg[o]);
      o = (o + 1) % 64;
    end
    expq.delete();
    gotq.delete();
    for (int i = 0; i < 64; i++)
      if (latch_m && v[i] && !guarded({a[13:6], i[5:0]}))
        expq.push_back({a[13:6], i[5:0], pg[i]});
    cmd(q);
    check(gotq.size(), expq.size());
    foreach (expq[i])
      if (i < gotq.size())
        check(gotq[i], expq[i]);
    latch_m = 0;
    check(latch, 0);
  endtask
  task conclude();
    $display("counts: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    check({latch, arm, g1, g0, hw_on, busy}, 0);
    wr(16'h1234, 3);
    lset(8'h0e);
    cmd('{8'h04});
    latch_m = 0;
    check(latch, 0);
    $display("test latch done");
    lset(8'h06);
    fork
      begin
        wait (busy === 1'b1);
        #1 stall = 1; // fifo fills, scan must stall
        repeat (150) @(posedge ref_clk_in);
        #1 stall = 0;
      end
    join_none
    wr(16'({$random(seed)} & 32'hffc0 | 32'h003c), 70);
    $display("test page done");
    host.park(1'b1); // guard tests run in mode 3
    lset(8'h06);
    sw(8'h84);
    #1 protect_b_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    check(hw_on, 1);
    lset(8'h06);
    wr(16'h2fe0, 64);
    lset(8'h06);
    wr(16'h3010, 5);
    lset(8'h06);
    sw(8'h00);
    #1 protect_b_in = 1'b1;
    repeat (8) @(posedge ref_clk_in);
    sw(8'h08);
    check(hw_on, 0);
    lset(8'h06);
    wr(16'h2010, 4);
    lset(8'h06);
    wr(16'h1ff0, 3);
    lset(8'h06);
    sw(8'h0c);
    lset(8'h06);
    wr(16'h0000, 2);
    lset(8'h06);
    sw(8'h00);
    $display("test guard done");
    host.park(1'b0);
    lset(8'h06);
    fork
      wr(16'h0100, 2);
      begin
        repeat (350) @(posedge ref_clk_in);
        host.send('{8'h06});
      end
    join
    $display("test busy done");
    conclude();
  end
endmodule
